// [core/fan_loop_defines.vh]
// Register map, field positions, reset values and limits of the fan threshold loop
`ifndef FAN_LOOP_DEFINES_VH
`define FAN_LOOP_DEFINES_VH
`define ADDR_ZONE1_TARGET  8'h5a
`define ADDR_ZONE2_TARGET  8'h5b
`define ADDR_TARGET_HYST   8'h64
`define ADDR_LOOP_ENABLE   8'h0b
`define ADDR_CYCLE_CODES   8'h0c
`define ADDR_ZONE1_START   8'h70
`define ADDR_ZONE2_START   8'h71
`define ADDR_ZONE1_LOW     8'h72
`define ADDR_ZONE2_LOW     8'h73
`define ADDR_ZONE1_HIGH    8'h74
`define ADDR_ZONE2_HIGH    8'h75
`define ADDR_ZONE1_CRIT    8'h76
`define ADDR_ZONE2_CRIT    8'h77
`define ADDR_ZONE1_SLOPE   8'h78
`define ADDR_ZONE2_SLOPE   8'h79
`define ADDR_LIMIT_STATUS  8'h7a
`define RST_TARGET_TEMP    8'ha4
`define RST_TARGET_HYST    8'h40
`define RST_START_TEMP     8'h5a
`define RST_LOW_LIMIT      8'h40
`define RST_HIGH_LIMIT     8'h96
`define RST_CRIT_LIMIT     8'ha4
`define RST_SLOPE          8'h04
`define HYST_MSB           7
`define HYST_LSB           4
`define CYCLE1_MSB         2
`define CYCLE1_LSB         0
`define CYCLE2_MSB         5
`define CYCLE2_LSB         3
`define START_TEMP_FLOOR   8'h00
`define SHORT_BASE_CYCLES  12'h008
`define TEMP_OFFSET        8'h40
`endif

// [core/zone_threshold_adjust.v]
// One zone of the adaptive fan start temperature loop
`timescale 1ns/100ps
`default_nettype none
`include "fan_loop_defines.vh"
module zone_threshold_adjust (
    // Clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // Timebase
    input  wire        monitorTick,
    // Zone settings
    input  wire        loopEnable,
    input  wire [2:0]  cycleCode,
    input  wire [7:0]  targetTemp,
    input  wire [3:0]  targetHyst,
    input  wire [7:0]  lowLimit,
    input  wire [7:0]  highLimit,
    input  wire [7:0]  zoneTemp,
    input  wire [7:0]  startInit,
    input  wire        startLoad,
    // Adjusted start temperature
    output reg  [7:0]  startTemp_r
);
    reg  [11:0] tickCount_r;
    reg  [7:0]  prevTemp_r;
    reg  [8:0]  cand;
    reg  [8:0]  dec;
    wire [11:0] shortLen = `SHORT_BASE_CYCLES << cycleCode;
    wire        shortDue = monitorTick && (tickCount_r == shortLen - 12'h001 ||
                                           tickCount_r == {shortLen[10:0], 1'b0} - 12'h001);
    wire        longDue  = monitorTick && (tickCount_r == {shortLen[10:0], 1'b0} - 12'h001);
    wire [7:0]  hystPoint = targetTemp - {4'h0, targetHyst};
    wire        rising    = zoneTemp > prevTemp_r;
    wire [7:0]  riseAmt   = zoneTemp - prevTemp_r;

    always @(posedge clock) begin
        if (sys_rst) begin
            tickCount_r <= 12'h000;
            prevTemp_r  <= 8'h00;
        end else if (monitorTick) begin
            // Short every n long every 2n
            tickCount_r <= longDue ? 12'h000 : tickCount_r + 12'h001;
            if (shortDue)
                prevTemp_r <= zoneTemp;
        end
    end

    always @* begin
        cand = {1'b0, startTemp_r};
        dec  = 9'h000;
        // Short cycle lowers start point, twice the rise
        if (shortDue && zoneTemp > hystPoint && rising)
            dec = {riseAmt, 1'b0};
        if (longDue && zoneTemp > targetTemp)
            dec = dec + 9'h001;
        if (dec + {1'b0, `START_TEMP_FLOOR} > cand)
            cand = {1'b0, `START_TEMP_FLOOR};
        else
            cand = cand - dec;
        // Long cycle raise by one degree
        if (longDue && zoneTemp < lowLimit && startTemp_r < highLimit &&
            startTemp_r < targetTemp)
            cand = cand + 9'h001;
        if (cand > {1'b0, highLimit} && cand > {1'b0, startTemp_r})
            cand = {1'b0, startTemp_r};
    end

    always @(posedge clock) begin
        if (sys_rst)
            startTemp_r <= `RST_START_TEMP;
        else if (startLoad)
            startTemp_r <= startInit;
        // Adjust only when enabled idle below start point raise
        else if (loopEnable && zoneTemp >= startTemp_r && (shortDue || longDue))
            startTemp_r <= cand[7:0];
    end
endmodule
`default_nettype wire

// [core/dynamic_fan_threshold_loop.v]
// Adaptive fan start temperature controller for two remote zones
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "fan_loop_defines.vh"
// Function
// - One 8-bit target per zone
// - Targets reset to 100 degrees code
// - Target hysteresis in upper nibble, default 4
// - Hot above target-hyst lowers start point
// - Cold below low limit raises start point
// - Below low limit sets status flag
// - Above high limit sets status flag
// - Short cycle every n monitor cycles
// - Long cycle every 2n monitor cycles
// - Cycle multiplier programmable per zone
// - Above critical limit forces full duty
// - Start point is fan switch-on temperature
// - Slope setting sets duty per degree
// - Each zone adjusted independently
// - Cycle code 000 is 8, doubling
// - Loop acts only when zone enabled
// - Clamp start point; idle below it
// - Long cycle above target lowers one
module dynamic_fan_threshold_loop (
    // Clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [7:0]  regRdData,
    // Measurement
    input  wire        monitorTick,
    input  wire [7:0]  zone1Temp,
    input  wire [7:0]  zone2Temp,
    // Fan control
    output reg  [7:0]  zone1Duty,
    output reg  [7:0]  zone2Duty,
    output reg         zone1FanOn,
    output reg         zone2FanOn,
    output reg         fullSpeed,
    output wire        limitAlert
);
    reg  [7:0] zone1Target_r, zone2Target_r, targetHyst_r, loopEnable_r, cycleCodes_r;
    reg  [7:0] zone1Low_r, zone2Low_r, zone1High_r, zone2High_r;
    reg  [7:0] zone1Crit_r, zone2Crit_r, zone1Slope_r, zone2Slope_r;
    reg  [3:0] status_r;
    reg  [3:0] statusSet;
    reg  [7:0] readNxt;
    wire [7:0] zone1Start, zone2Start;
    wire       wrStart1 = regWrite && regAddr == `ADDR_ZONE1_START;
    wire       wrStart2 = regWrite && regAddr == `ADDR_ZONE2_START;

    always @(posedge clock) begin
        if (sys_rst) begin
            zone1Target_r <= `RST_TARGET_TEMP;
            zone2Target_r <= `RST_TARGET_TEMP;
            targetHyst_r  <= `RST_TARGET_HYST;
            loopEnable_r  <= 8'h00;
            cycleCodes_r  <= 8'h00;
            zone1Low_r    <= `RST_LOW_LIMIT;
            zone2Low_r    <= `RST_LOW_LIMIT;
            zone1High_r   <= `RST_HIGH_LIMIT;
            zone2High_r   <= `RST_HIGH_LIMIT;
            zone1Crit_r   <= `RST_CRIT_LIMIT;
            zone2Crit_r   <= `RST_CRIT_LIMIT;
            zone1Slope_r  <= `RST_SLOPE;
            zone2Slope_r  <= `RST_SLOPE;
        end else if (regWrite) begin
            if (regAddr == `ADDR_ZONE1_TARGET)
                zone1Target_r <= regWrData;
            else if (regAddr == `ADDR_ZONE2_TARGET)
                zone2Target_r <= regWrData;
            else if (regAddr == `ADDR_TARGET_HYST)
                targetHyst_r <= {regWrData[`HYST_MSB:`HYST_LSB], 4'h0};
            else if (regAddr == `ADDR_LOOP_ENABLE)
                loopEnable_r <= {6'h00, regWrData[1:0]};
            else if (regAddr == `ADDR_CYCLE_CODES)
                cycleCodes_r <= {2'b00, regWrData[5:0]};
            else if (regAddr == `ADDR_ZONE1_LOW)
                zone1Low_r <= regWrData;
            else if (regAddr == `ADDR_ZONE2_LOW)
                zone2Low_r <= regWrData;
            else if (regAddr == `ADDR_ZONE1_HIGH)
                zone1High_r <= regWrData;
            else if (regAddr == `ADDR_ZONE2_HIGH)
                zone2High_r <= regWrData;
            else if (regAddr == `ADDR_ZONE1_CRIT)
                zone1Crit_r <= regWrData;
            else if (regAddr == `ADDR_ZONE2_CRIT)
                zone2Crit_r <= regWrData;
            else if (regAddr == `ADDR_ZONE1_SLOPE)
                zone1Slope_r <= regWrData;
            else if (regAddr == `ADDR_ZONE2_SLOPE)
                zone2Slope_r <= regWrData;
        end
    end

    zone_threshold_adjust zone1Loop (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .monitorTick (monitorTick),
        .loopEnable  (loopEnable_r[0]),
        .cycleCode   (cycleCodes_r[`CYCLE1_MSB:`CYCLE1_LSB]),
        .targetTemp  (zone1Target_r),
        .targetHyst  (targetHyst_r[`HYST_MSB:`HYST_LSB]),
        .lowLimit    (zone1Low_r),
        .highLimit   (zone1High_r),
        .zoneTemp    (zone1Temp),
        .startInit   (regWrData),
        .startLoad   (wrStart1),
        .startTemp_r (zone1Start)
    );

    zone_threshold_adjust zone2Loop (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .monitorTick (monitorTick),
        .loopEnable  (loopEnable_r[1]),
        .cycleCode   (cycleCodes_r[`CYCLE2_MSB:`CYCLE2_LSB]),
        .targetTemp  (zone2Target_r),
        .targetHyst  (targetHyst_r[`HYST_MSB:`HYST_LSB]),
        .lowLimit    (zone2Low_r),
        .highLimit   (zone2High_r),
        .zoneTemp    (zone2Temp),
        .startInit   (regWrData),
        .startLoad   (wrStart2),
        .startTemp_r (zone2Start)
    );

    always @* begin
        statusSet = 4'h0;
        if (monitorTick) begin
            statusSet[0] = zone1Temp < zone1Low_r;
            statusSet[1] = zone2Temp < zone2Low_r;
            statusSet[2] = zone1Temp > zone1High_r;
            statusSet[3] = zone2Temp > zone2High_r;
        end
    end

    // Sticky flags; a new event in the read cycle survives the clear
    always @(posedge clock) begin
        if (sys_rst)
            status_r <= 4'h0;
        else if (regRead && regAddr == `ADDR_LIMIT_STATUS)
            status_r <= statusSet;
        else
            status_r <= status_r | statusSet;
    end

    assign limitAlert = |status_r;

    // Duty above start point follows the slope; start point gates the fan
    function [7:0] dutyCalc;
        input [7:0] temp;
        input [7:0] start;
        input [7:0] slope;
        reg   [15:0] prod;
        begin
            prod = 16'h0000;
            if (temp > start)
                prod = {8'h00, temp - start} * {8'h00, slope};
            dutyCalc = (prod > 16'h00ff) ? 8'hff : prod[7:0];
        end
    endfunction

    always @(posedge clock) begin
        if (sys_rst) begin
            zone1Duty  <= 8'h00;
            zone2Duty  <= 8'h00;
            zone1FanOn <= 1'b0;
            zone2FanOn <= 1'b0;
            fullSpeed  <= 1'b0;
        end else begin
            zone1FanOn <= zone1Temp > zone1Start;
            zone2FanOn <= zone2Temp > zone2Start;
            fullSpeed  <= zone1Temp > zone1Crit_r || zone2Temp > zone2Crit_r;
            if (zone1Temp > zone1Crit_r || zone2Temp > zone2Crit_r) begin
                zone1Duty <= 8'hff;
                zone2Duty <= 8'hff;
            end else begin
                zone1Duty <= dutyCalc(zone1Temp, zone1Start, zone1Slope_r);
                zone2Duty <= dutyCalc(zone2Temp, zone2Start, zone2Slope_r);
            end
        end
    end

    always @* begin
        readNxt = 8'h00;
        if (regAddr == `ADDR_ZONE1_TARGET)
            readNxt = zone1Target_r;
        else if (regAddr == `ADDR_ZONE2_TARGET)
            readNxt = zone2Target_r;
        else if (regAddr == `ADDR_TARGET_HYST)
            readNxt = targetHyst_r;
        else if (regAddr == `ADDR_LOOP_ENABLE)
            readNxt = loopEnable_r;
        else if (regAddr == `ADDR_CYCLE_CODES)
            readNxt = cycleCodes_r;
        else if (regAddr == `ADDR_ZONE1_START)
            readNxt = zone1Start;
        else if (regAddr == `ADDR_ZONE2_START)
            readNxt = zone2Start;
        else if (regAddr == `ADDR_ZONE1_LOW)
            readNxt = zone1Low_r;
        else if (regAddr == `ADDR_ZONE2_LOW)
            readNxt = zone2Low_r;
        else if (regAddr == `ADDR_ZONE1_HIGH)
            readNxt = zone1High_r;
        else if (regAddr == `ADDR_ZONE2_HIGH)
            readNxt = zone2High_r;
        else if (regAddr == `ADDR_ZONE1_CRIT)
            readNxt = zone1Crit_r;
        else if (regAddr == `ADDR_ZONE2_CRIT)
            readNxt = zone2Crit_r;
        else if (regAddr == `ADDR_ZONE1_SLOPE)
            readNxt = zone1Slope_r;
        else if (regAddr == `ADDR_ZONE2_SLOPE)
            readNxt = zone2Slope_r;
        else if (regAddr == `ADDR_LIMIT_STATUS)
            readNxt = {4'h0, status_r};
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge clock) begin
        if (sys_rst)
            regRdData <= 8'h00;
        else if (regRead)
            regRdData <= readNxt;
        else
            regRdData <= 8'h00;
    end
endmodule
`default_nettype wire

// [verif/fan_loop_monitor.sv]
// Port-level checks for the adaptive fan start temperature loop
`timescale 1ns/100ps
`default_nettype none
module fan_loop_monitor (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // Measurement and fan control
    input wire logic       monitorTick,
    input wire logic [7:0] zone1Duty,
    input wire logic [7:0] zone2Duty,
    input wire logic       zone1FanOn,
    input wire logic       fullSpeed,
    input wire logic       limitAlert
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_rdIdle;
        (regRdData != 8'h00) |-> $past(regRead);
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("Read data outside its slot");
    // The idle cycle between write and read is what the bench produces
    property p_targetBack;
        regWrite && regAddr == 8'h5a ##1 !regWrite ##1 regRead && regAddr == 8'h5a
            |=> regRdData == $past(regWrData, 3);
    endproperty
    a_targetBack: assert property (p_targetBack)
        else $error("Target readback wrong");
    property p_hystBack;
        regWrite && regAddr == 8'h64 ##1 !regWrite ##1 regRead && regAddr == 8'h64
            |=> regRdData == {$past(regWrData[7:4], 3), 4'h0};
    endproperty
    a_hystBack: assert property (p_hystBack)
        else $error("Hysteresis readback wrong");
    property p_enableBits;
        regRead && regAddr == 8'h0b |=> regRdData[7:2] == 6'h00;
    endproperty
    a_enableBits: assert property (p_enableBits)
        else $error("Enable register upper bits set");
    property p_fullDuty;
        fullSpeed |-> zone1Duty == 8'hff && zone2Duty == 8'hff;
    endproperty
    a_fullDuty: assert property (p_fullDuty)
        else $error("Full speed without full duty");
    property p_alertRise;
        $rose(limitAlert) |-> $past(monitorTick);
    endproperty
    a_alertRise: assert property (p_alertRise)
        else $error("Alert rose without a monitor tick");
    property p_alertClear;
        regRead && regAddr == 8'h7a && !monitorTick |=> !limitAlert;
    endproperty
    a_alertClear: assert property (p_alertClear)
        else $error("Alert kept after status read");
    property p_fanOffDuty;
        !zone1FanOn && !fullSpeed |-> zone1Duty == 8'h00;
    endproperty
    a_fanOffDuty: assert property (p_fanOffDuty)
        else $error("Duty while fan is off");
    c_full: cover property (fullSpeed);
    c_alert: cover property ($rose(limitAlert));
    c_status: cover property (regRead && regAddr == 8'h7a ##1 regRdData != 8'h00);
endmodule
bind dynamic_fan_threshold_loop fan_loop_monitor checker0 (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .monitorTick(monitorTick), .zone1Duty(zone1Duty), .zone2Duty(zone2Duty),
    .zone1FanOn(zone1FanOn), .fullSpeed(fullSpeed), .limitAlert(limitAlert)
);
`default_nettype wire

// [verif/test_dynamic_fan_threshold_loop.sv]
// Self-checking testbench for the adaptive fan start temperature loop
`timescale 1ns/100ps
`default_nettype none
`include "fan_loop_defines.vh"
module test_dynamic_fan_threshold_loop;
    logic       clock       = 1'b0;
    logic       sys_rst     = 1'b1;
    logic [7:0] regAddr     = 8'h00;
    logic [7:0] regWrData   = 8'h00;
    logic       regWrite    = 1'b0;
    logic       regRead     = 1'b0;
    logic       monitorTick = 1'b0;
    logic [7:0] zone1Temp   = 8'h50;
    logic [7:0] zone2Temp   = 8'h50;
    wire  [7:0] regRdData, zone1Duty, zone2Duty;
    wire        zone1FanOn, zone2FanOn, fullSpeed, limitAlert;
    int         mismatches  = 0;
    int         comparisons = 0;
    int         seed        = 32'h3a6b260f;
    logic [7:0] wrVal, addrVal;
    logic [7:0] addrTab [5] = '{8'h5a, 8'h5b, 8'h64, 8'h0b, 8'h0c};
    dynamic_fan_threshold_loop dut (
        .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .monitorTick(monitorTick), .zone1Temp(zone1Temp), .zone2Temp(zone2Temp),
        .zone1Duty(zone1Duty), .zone2Duty(zone2Duty), .zone1FanOn(zone1FanOn),
        .zone2FanOn(zone2FanOn), .fullSpeed(fullSpeed), .limitAlert(limitAlert)
    );
    initial begin
        forever #10 clock = ~clock;
    end
    function automatic logic [7:0] regMask(input logic [7:0] a);
        case (a)
            `ADDR_TARGET_HYST: regMask = 8'hf0;
            `ADDR_LOOP_ENABLE: regMask = 8'h03;
            `ADDR_CYCLE_CODES: regMask = 8'h3f;
            default:           regMask = 8'hff;
        endcase
    endfunction
    // Duty rises by the slope per degree above the start point, saturating
    function automatic logic [7:0] expDuty(input logic [7:0] t, input logic [7:0] s,
                                           input logic [7:0] k);
        int p;
        p = (t > s) ? (int'(t) - int'(s)) * int'(k) : 0;
        expDuty = (p > 255) ? 8'hff : 8'(p);
    endfunction
    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk8(exp, regRdData);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            monitorTick <= 1'b1;
            @(posedge clock);
            monitorTick <= 1'b0;
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rdChk(`ADDR_ZONE1_TARGET, 8'ha4);
        rdChk(`ADDR_ZONE2_TARGET, 8'ha4);
        rdChk(`ADDR_TARGET_HYST, 8'h40);
        rdChk(`ADDR_LOOP_ENABLE, 8'h00);
        rdChk(`ADDR_CYCLE_CODES, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 15; i++) begin
            addrVal = addrTab[i % 5];
            wrVal = 8'($random(seed));
            wr(addrVal, wrVal);
            rdChk(addrVal, wrVal & regMask(addrVal));
        end
        wr(8'h10, 8'hff);
        rdChk(8'h10, 8'h00);
        $display("test register access done");
        @(posedge clock);
        zone1Temp <= 8'h30;
        zone2Temp <= 8'ha8;
        tick(1);
        repeat (2) @(posedge clock);
        #1;
        chk1(1'b1, limitAlert);
        chk1(1'b1, fullSpeed);
        chk8(8'hff, zone2Duty);
        rdChk(`ADDR_LIMIT_STATUS, 8'h09);
        rdChk(`ADDR_LIMIT_STATUS, 8'h00);
        chk1(1'b0, limitAlert);
        @(posedge clock);
        zone1Temp <= 8'ha0;
        zone2Temp <= 8'h30;
        tick(1);
        rdChk(`ADDR_LIMIT_STATUS, 8'h06);
        chk1(1'b0, fullSpeed);
        chk1(1'b0, zone2FanOn);
        chk8(expDuty(8'h30, `RST_START_TEMP, `RST_SLOPE), zone2Duty);
        chk1(1'b1, zone1FanOn);
        chk8(expDuty(8'ha0, `RST_START_TEMP, `RST_SLOPE), zone1Duty);
        $display("test limit status done");
        // Second reset restores defaults and clears the cycle counters
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        zone1Temp <= 8'h38;
        zone2Temp <= 8'h38;
        rdChk(`ADDR_ZONE1_TARGET, 8'ha4);
        wr(`ADDR_ZONE1_START, 8'h30);
        wr(`ADDR_ZONE2_START, 8'h30);
        wr(`ADDR_LOOP_ENABLE, 8'h01);
        tick(15);
        rdChk(`ADDR_ZONE1_START, 8'h30);
        tick(1);
        rdChk(`ADDR_ZONE1_START, 8'h31);
        rdChk(`ADDR_ZONE2_START, 8'h30);
        wr(`ADDR_CYCLE_CODES, 8'h01);
        tick(31);
        rdChk(`ADDR_ZONE1_START, 8'h31);
        tick(1);
        rdChk(`ADDR_ZONE1_START, 8'h32);
        $display("test long cycle raise done");
        wr(`ADDR_CYCLE_CODES, 8'h00);
        wr(`ADDR_ZONE1_LOW, 8'h20);
        wr(`ADDR_ZONE1_TARGET, 8'h3a);
        @(posedge clock);
        zone1Temp <= 8'h3d;
        tick(8);
        rdChk(`ADDR_ZONE1_START, 8'h28);
        chk8(expDuty(8'h3d, 8'h28, `RST_SLOPE), zone1Duty);
        chk1(1'b1, zone1FanOn);
        chk8(expDuty(8'h38, 8'h30, `RST_SLOPE), zone2Duty);
        chk1(1'b1, zone2FanOn);
        tick(8);
        rdChk(`ADDR_ZONE1_START, 8'h27);
        @(posedge clock);
        zone1Temp <= 8'h7d;
        tick(8);
        rdChk(`ADDR_ZONE1_START, 8'h00);
        $display("test short cycle lower done");
        conclude();
    end
endmodule
`default_nettype wire
